/* verilog/wdrcf_pkg.sv */
// Package holding the watchdog and reset-cause register map, field layout and helper functions.
package wdrcf_pkg;

  localparam int          ADDR_W          = 12;
  localparam logic [7:0]  CAUSE_INDEX     = 8'h35;
  localparam logic [7:0]  CTRL_INDEX      = 8'h60;
  localparam logic [11:0] CAUSE_ADDR      = {2'b00, CAUSE_INDEX, 2'b00};
  localparam logic [11:0] CTRL_ADDR       = {2'b00, CTRL_INDEX, 2'b00};

  localparam int          POWERUP_BIT     = 0;
  localparam int          PIN_BIT         = 1;
  localparam int          BROWNOUT_BIT    = 2;
  localparam int          DOGRST_BIT      = 3;

  localparam int          RESET_EN_BIT    = 3;
  localparam int          UNLOCK_BIT      = 4;
  localparam int          PERIOD_MSB_BIT  = 5;
  localparam int          IRQ_EN_BIT      = 6;
  localparam int          TIMEOUT_BIT     = 7;

  localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;
  localparam int          CNT_W           = 20;
  localparam int          DOG_BASE_LOG2   = 11;
  localparam logic [3:0]  PERIOD_MAX_CODE = 4'h9;
  localparam logic        FUSE_PROGRAMMED = 1'b0;

  typedef struct packed {
    logic       timeout;
    logic       irq_en;
    logic       unlock;
    logic       reset_en;
    logic [3:0] period;
  } wdrcf_ctrl_t;

  typedef struct packed {
    logic dog;
    logic brownout;
    logic pin;
    logic powerup;
  } wdrcf_cause_t;

  typedef enum {MODE_STOPPED, MODE_IRQ, MODE_RESET, MODE_BOTH} wdrcf_mode_t;

  localparam wdrcf_ctrl_t  CTRL_RESET  = '{timeout: 1'b0, irq_en: 1'b0, unlock: 1'b0,
                                           reset_en: 1'b0, period: 4'h0};
  localparam wdrcf_cause_t CAUSE_RESET = '{dog: 1'b0, brownout: 1'b0, pin: 1'b0,
                                           powerup: 1'b1};

  // Reserved codes fall back to the longest period so a stray code never shortens time-out.
  function automatic logic [CNT_W-1:0] period_last(input logic [3:0] code,
                                                   input int         base_log2);
    logic [3:0]     c;
    logic [CNT_W:0] span;
    c    = (code > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : code;
    span = (CNT_W+1)'(1) << (base_log2 + int'(c));
    return CNT_W'(span - (CNT_W+1)'(1));
  endfunction

  function automatic wdrcf_mode_t dog_mode(input logic fuse,
                                           input logic rst_en,
                                           input logic irq_en);
    wdrcf_mode_t m;
    m = MODE_RESET;
    if (fuse != FUSE_PROGRAMMED) begin
      case ({rst_en, irq_en})
        2'b00:   m = MODE_STOPPED;
        2'b01:   m = MODE_IRQ;
        2'b10:   m = MODE_RESET;
        2'b11:   m = MODE_BOTH;
        default: m = MODE_RESET;
      endcase
    end
    return m;
  endfunction

endpackage

/* verilog/wdrcf_counter.sv */
// Time-out counter advancing on oscillator ticks against the selected period.
module wdrcf_counter #(
  parameter int BASE_LOG2 = wdrcf_pkg::DOG_BASE_LOG2
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     tick,
  input  wire logic                     restart,
  input  wire logic                     enable,
  input  wire logic [3:0]               period,
  output logic                          expire
);
  import wdrcf_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;
  logic             at_end;
  logic [CNT_W-1:0] next_count;
  logic             next_expire;

  assign last        = period_last(period, BASE_LOG2);
  assign at_end      = tick && enable && (count >= last);
  // Restart has priority so a restart in the tick of expiry still saves the system.
  assign next_count  = (restart || !enable) ? '0 :
                       at_end ? '0 :
                       tick ? count + CNT_W'(1) : count;
  assign next_expire = at_end && !restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= '0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      expire <= next_expire;
    end
  end

  restart_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> (count == '0))
    else $error("count not zero after restart");

  period_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && enable && !restart && count == last && $stable(period)) |=> expire && count == '0)
    else $error("no expiry at end of period");

endmodule

/* verilog/wdrcf_top.sv */
// Watchdog with reset-cause flags behind an APB slave.
import wdrcf_pkg::*;

// Overview of operation
// - Upper four reset-cause bits always read zero.
// - Watchdog-reset flag sets on watchdog reset; power-on or software zero clears it.
// - Brown-out flag sets on brown-out reset; power-on or software zero clears it.
// - Pin-reset flag sets on external reset; power-on or software zero clears it.
// - Power-up flag sets at power-on; only a software zero clears it.
// - Time-out flag sets in interrupt modes; vector execution or writing one clears.
// - Interrupt is taken only with global enable, interrupt enable and flag all set.
// - Reset-enable and interrupt-enable pick stopped, interrupt, reset or combined mode.
// - Programmed force-on fuse means reset mode, ignoring both enable bits.
// - In combined mode vector execution clears interrupt enable and time-out flag.
// - Combined mode: second time-out before service gives a system reset.
// - Clearing reset-enable or changing period needs the unlock bit set.
// - Unlock bit clears itself four clock cycles after being written to one.
// - Reset-enable reads set while watchdog-reset flag is set; clear flag first.
// - Period code picks 2048 oscillator cycles doubling up to 1048576 cycles.
// - Unlock: write unlock and reset-enable as one, then new values within four cycles.
// - Counter advances on oscillator ticks; restart instruction zeroes it.
// - Programmed fuse locks reset-enable at one and interrupt-enable at zero.
// - Watchdog reset is a one system clock cycle pulse.
module wdrcf_top #(
  parameter int BASE_LOG2 = wdrcf_pkg::DOG_BASE_LOG2
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [wdrcf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        osc_tick,
  input  wire logic                        restart_strobe,
  input  wire logic                        pin_reset_event,
  input  wire logic                        brownout_reset_event,
  input  wire logic                        dog_force_on_fuse,
  input  wire logic                        global_irq_enable,
  input  wire logic                        irq_vector_ack,
  output logic                             dog_irq,
  output logic                             dog_sys_reset
);
  import wdrcf_pkg::*;

  wdrcf_ctrl_t  ctrl;
  wdrcf_cause_t cause;
  logic [2:0]   unlock_cnt;

  wdrcf_ctrl_t  next_ctrl;
  wdrcf_cause_t next_cause;
  logic [2:0]   next_unlock_cnt;
  logic         next_pready;
  logic [31:0]  next_prdata;
  logic         next_irq;

  wire logic        hit_cause   = (paddr == CAUSE_ADDR);
  wire logic        hit_ctrl    = (paddr == CTRL_ADDR);
  wire logic        wr_done     = psel && penable && pready && pwrite;
  wire logic        wr_cause    = wr_done && hit_cause;
  wire logic        wr_ctrl     = wr_done && hit_ctrl;
  wire logic [7:0]  wbyte       = pwdata[7:0];
  wire logic        fuse_forced = (dog_force_on_fuse == FUSE_PROGRAMMED);

  // A watchdog reset is never blocked while its cause flag is set.
  wire logic        rst_en_eff  = ctrl.reset_en || cause.dog || fuse_forced;
  wire logic        irq_en_eff  = ctrl.irq_en && !fuse_forced;
  wdrcf_mode_t      mode;
  assign mode = dog_mode(dog_force_on_fuse, rst_en_eff,
                         irq_en_eff);

  wire logic        expire;
  wire logic        timeout_set = expire && ((mode == MODE_IRQ) ||
                                  ((mode == MODE_BOTH) && !ctrl.timeout));
  wire logic        fire        = expire && ((mode == MODE_RESET) ||
                                  ((mode == MODE_BOTH) && ctrl.timeout));
  wire logic        ack_take    = irq_vector_ack && dog_irq;
  wire logic        sys_event   = fire || pin_reset_event || brownout_reset_event;
  wire logic        arm_unlock  = wr_ctrl && wbyte[UNLOCK_BIT] && wbyte[RESET_EN_BIT];
  wire logic        may_change  = ctrl.unlock;

  wire logic [7:0]  cause_rd    = {4'h0, cause.dog, cause.brownout, cause.pin,
                                   cause.powerup};
  wire logic [7:0]  ctrl_rd     = {ctrl.timeout, irq_en_eff, ctrl.period[3], ctrl.unlock,
                                   rst_en_eff, ctrl.period[2:0]};

  wdrcf_counter #(
    .BASE_LOG2 (BASE_LOG2)
  ) u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (osc_tick),
    .restart (restart_strobe || sys_event),
    .enable  (mode != MODE_STOPPED),
    .period  (ctrl.period),
    .expire  (expire)
  );

  // Reset-cause flags: every hardware set wins over a software clear in the same cycle.
  always_comb begin
    next_cause          = cause;
    next_cause.dog      = fire ||
                          (cause.dog && !(wr_cause && !wbyte[DOGRST_BIT]));
    next_cause.brownout = brownout_reset_event ||
                          (cause.brownout && !(wr_cause && !wbyte[BROWNOUT_BIT]));
    next_cause.pin      = pin_reset_event ||
                          (cause.pin && !(wr_cause && !wbyte[PIN_BIT]));
    next_cause.powerup  = cause.powerup && !(wr_cause && !wbyte[POWERUP_BIT]);
  end

  always_comb begin
    next_ctrl       = ctrl;
    next_unlock_cnt = unlock_cnt;
    if (sys_event) begin
      next_ctrl       = CTRL_RESET;
      next_unlock_cnt = 3'h0;
    end else begin
      if (unlock_cnt != 3'h0) begin
        next_unlock_cnt = unlock_cnt - 3'h1;
      end
      if (unlock_cnt == 3'h1) begin
        next_ctrl.unlock = 1'b0;
      end
      if (wr_ctrl) begin
        next_ctrl.irq_en = wbyte[IRQ_EN_BIT];
        if (wbyte[RESET_EN_BIT]) begin
          next_ctrl.reset_en = 1'b1;
        end else if (may_change) begin
          next_ctrl.reset_en = 1'b0;
        end
        if (may_change) begin
          next_ctrl.period = {wbyte[PERIOD_MSB_BIT], wbyte[2:0]};
        end
        if (wbyte[TIMEOUT_BIT]) begin
          next_ctrl.timeout = 1'b0;
        end
      end
      if (arm_unlock) begin
        next_ctrl.unlock = 1'b1;
        next_unlock_cnt  = UNLOCK_CYCLES;
      end
      // Vector execution clears the flag, and in combined mode drops to reset-only.
      if (ack_take) begin
        next_ctrl.timeout = 1'b0;
        if (mode == MODE_BOTH && !(wr_ctrl && wbyte[IRQ_EN_BIT])) begin
          next_ctrl.irq_en = 1'b0;
        end
      end
      if (timeout_set) begin
        next_ctrl.timeout = 1'b1;
      end
    end
    next_ctrl.reset_en = next_ctrl.reset_en || next_cause.dog || fuse_forced;
    if (fuse_forced) begin
      next_ctrl.irq_en = 1'b0;
    end
  end

  // The interrupt line only follows the flag while both enables allow it.
  assign next_irq = next_ctrl.timeout && next_ctrl.irq_en && !fuse_forced &&
                    global_irq_enable;

  // One wait state: pready and read data are registered in the first access cycle.
  assign next_pready = psel && penable && !pready;
  assign next_prdata = hit_cause ? {24'h000000, cause_rd} :
                       hit_ctrl  ? {24'h000000, ctrl_rd}  : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= CTRL_RESET;
      cause      <= CAUSE_RESET;
      unlock_cnt <= 3'h0;
    end else begin
      ctrl       <= next_ctrl;
      cause      <= next_cause;
      unlock_cnt <= next_unlock_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      prdata        <= 32'h00000000;
      dog_irq       <= 1'b0;
      dog_sys_reset <= 1'b0;
    end else begin
      pready        <= next_pready;
      pslverr       <= next_pready && !(hit_cause || hit_ctrl);
      prdata        <= next_pready ? next_prdata : prdata;
      dog_irq       <= next_irq;
      dog_sys_reset <= fire;
    end
  end

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_cause) |-> (prdata[31:4] == 28'h0))
    else $error("reserved reset-cause bits not zero");

  dog_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    fire |=> cause.dog && dog_sys_reset)
    else $error("watchdog reset flag not set");

  brownout_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    brownout_reset_event |=> cause.brownout)
    else $error("brown-out flag lost");

  pin_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_reset_event |=> cause.pin)
    else $error("pin reset flag lost");

  powerup_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cause.powerup && !(wr_cause && !wbyte[POWERUP_BIT])) |=> cause.powerup)
    else $error("power-up flag cleared without a write of zero");

  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    dog_irq |-> (ctrl.timeout && ctrl.irq_en && $past(global_irq_enable)))
    else $error("interrupt without flag and enables");

  irq_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && mode == MODE_IRQ) |=> (ctrl.timeout && !dog_sys_reset))
    else $error("interrupt mode time-out misbehaved");

  fuse_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fuse_forced && $past(fuse_forced) && $past(presetn)) |->
      (mode == MODE_RESET && !ctrl.irq_en && ctrl.reset_en))
    else $error("programmed fuse did not force reset mode");

  combined_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_take && mode == MODE_BOTH && !wr_ctrl && !sys_event) |=> (!ctrl.irq_en && !ctrl.timeout))
    else $error("vector did not leave combined mode");

  second_timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && mode == MODE_BOTH && ctrl.timeout) |=> dog_sys_reset)
    else $error("second time-out gave no reset");

  locked_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !ctrl.unlock && !sys_event) |=> $stable(ctrl.period))
    else $error("period changed while locked");

  unlock_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(ctrl.unlock) && !wr_ctrl && !sys_event) |-> ctrl.unlock [*4]
      ##1 (!ctrl.unlock || $past(arm_unlock)))
    else $error("unlock window not four cycles");

  reset_en_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    cause.dog |-> ctrl.reset_en)
    else $error("reset enable clear while watchdog flag set");

  reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    dog_sys_reset |=> !dog_sys_reset)
    else $error("reset pulse longer than one cycle");

  // The dog, brown-out and pin clear paths are checked alone, because a lost clear hides easily from software.
  prdata_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (prdata[31:8] == 24'h000000))
    else $error("read data above the low byte not zero");

  dog_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cause && !wbyte[DOGRST_BIT] && !fire) |=> !cause.dog)
    else $error("watchdog reset flag not cleared by a zero write");

  brownout_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cause && !wbyte[BROWNOUT_BIT] && !brownout_reset_event) |=> !cause.brownout)
    else $error("brown-out flag not cleared by a zero write");

  pin_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cause && !wbyte[PIN_BIT] && !pin_reset_event) |=> !cause.pin)
    else $error("pin reset flag not cleared by a zero write");

  timeout_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((ack_take || (wr_ctrl && wbyte[TIMEOUT_BIT])) && !timeout_set) |=> !ctrl.timeout)
    else $error("time-out flag not cleared");

  irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.timeout && ctrl.irq_en && global_irq_enable && !fuse_forced && !wr_ctrl &&
     !ack_take && !sys_event) |=> dog_irq)
    else $error("interrupt not raised with flag and enables set");

  stopped_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_STOPPED) |=> !dog_sys_reset)
    else $error("reset pulse while stopped");

  fuse_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && fuse_forced) |=> dog_sys_reset)
    else $error("programmed fuse time-out gave no reset");

  locked_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !ctrl.unlock && ctrl.reset_en && !sys_event) |=> ctrl.reset_en)
    else $error("reset enable cleared while locked");

  unlock_lapse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (unlock_cnt == 3'h1 && !arm_unlock) |=> !ctrl.unlock)
    else $error("unlock bit outlived its window");

  fuse_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fuse_forced && $past(fuse_forced)) |-> !dog_irq)
    else $error("interrupt raised with programmed fuse");

endmodule

/* verif/wdrcf_tb.sv */
// Self-checking testbench for the watchdog with reset-cause flags.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import wdrcf_pkg::*;

  logic        pclk                 = 1'b0;
  logic        presetn              = 1'b0;
  logic        psel                 = 1'b0;
  logic        penable              = 1'b0;
  logic        pwrite               = 1'b0;
  logic [11:0] paddr                = 12'h000;
  logic [31:0] pwdata               = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_tick             = 1'b0;
  logic        restart_strobe       = 1'b0;
  logic        pin_reset_event      = 1'b0;
  logic        brownout_reset_event = 1'b0;
  logic        dog_force_on_fuse    = 1'b1;
  logic        global_irq_enable    = 1'b0;
  logic        irq_vector_ack       = 1'b0;
  logic        dog_irq;
  logic        dog_sys_reset;
  logic        tick_en              = 1'b0;
  int          rcnt                 = 0;
  int          r0                   = 0;
  logic [1:0]  div                  = 2'h0;
  logic [31:0] rd;
  logic        er;
  logic        hit;
  int          tcnt                 = 0;
  int          t0                   = 0;
  int          mismatches           = 0;
  int          cmp_count            = 0;

  wdrcf_top #(.BASE_LOG2(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(osc_tick), .restart_strobe(restart_strobe), .pin_reset_event(pin_reset_event),
    .brownout_reset_event(brownout_reset_event), .dog_force_on_fuse(dog_force_on_fuse),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
    .dog_irq(dog_irq), .dog_sys_reset(dog_sys_reset));

  always #2.5 pclk = ~pclk;

  // Oscillator ticks come every fourth clock so no extra tick hides in the time-out latency.
  always @(posedge pclk) begin
    div <= tick_en ? div + 2'h1 : div;
    osc_tick <= tick_en && (div == 2'h3);
    if (osc_tick) tcnt <= tcnt + 1;
    if (dog_sys_reset === 1'b1) rcnt <= rcnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("read_data", {24'h000000, e}, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask

  // Timed sequence: arm the unlock window, then the real value with unlock clear.
  task automatic setc(input logic [7:0] d);
    wr(CTRL_ADDR, 8'h18);
    wr(CTRL_ADDR, d);
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: pin_reset_event <= 1'b1;
      1: brownout_reset_event <= 1'b1;
      2: irq_vector_ack <= 1'b1;
      default: restart_strobe <= 1'b1;
    endcase
    @(posedge pclk);
    pin_reset_event <= 1'b0;
    brownout_reset_event <= 1'b0;
    irq_vector_ack <= 1'b0;
    restart_strobe <= 1'b0;
  endtask

  task automatic go();
    pulse(3);
    t0 = tcnt;
    r0 = rcnt;
    tick_en <= 1'b1;
  endtask

  task automatic wait_evt(input logic irq, input int lim, input logic stop);
    int n;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(posedge pclk);
      hit = irq ? (dog_irq === 1'b1) : (dog_sys_reset === 1'b1);
    end
    if (stop) tick_en <= 1'b0;
    if (hit && !irq) begin
      @(posedge pclk);
      chk("reset_pulse_end", 32'h0, {31'h0, dog_sys_reset});
    end
  endtask

  task automatic t_reset();
    rdc(CAUSE_ADDR, 8'h01);
    rdc(CTRL_ADDR, 8'h00);
    go();
    repeat (40) @(posedge pclk);
    tick_en <= 1'b0;
    chk("stopped_reset", 32'h0, 32'(rcnt - r0));
    chk("stopped_irq", 32'h0, {31'h0, dog_irq});
  endtask

  task automatic t_cause();
    pulse(0);
    pulse(1);
    rdc(CAUSE_ADDR, 8'h07);
    wr(CAUSE_ADDR, 8'hFF);
    rdc(CAUSE_ADDR, 8'h07);
    wr(CAUSE_ADDR, 8'h06);
    rdc(CAUSE_ADDR, 8'h06);
    wr(CAUSE_ADDR, 8'h00);
    rdc(CAUSE_ADDR, 8'h00);
    apb(1'b0, 12'h004, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
  endtask

  task automatic t_lock();
    wr(CTRL_ADDR, 8'h01);
    rdc(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h0B);
    rdc(CTRL_ADDR, 8'h08);
    wr(CTRL_ADDR, 8'h18);
    repeat (8) @(posedge pclk);
    wr(CTRL_ADDR, 8'h03);
    rdc(CTRL_ADDR, 8'h08);
    setc(8'h00);
    rdc(CTRL_ADDR, 8'h00);
  endtask

  task automatic t_period();
    logic [3:0] c;
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      c = 4'(i);
      d = {2'b00, c[3], 2'b01, c[2:0]};
      wr(CAUSE_ADDR, 8'h00);
      setc(d);
      rdc(CTRL_ADDR, d);
      go();
      wait_evt(1'b0, 9000, 1'b1);
      chk("timeout_seen", 32'h1, {31'h0, hit});
      chk("timeout_ticks", 32'(1 << (2 + i)), 32'(tcnt - t0));
    end
    wr(CAUSE_ADDR, 8'h00);
    setc(8'h00);
  endtask

  task automatic t_restart();
    wr(CTRL_ADDR, 8'h08);
    go();
    repeat (25) begin
      repeat (6) @(posedge pclk);
      pulse(3);
    end
    tick_en <= 1'b0;
    chk("restart_holds", 32'h0, 32'(rcnt - r0));
    setc(8'h00);
  endtask

  task automatic t_irq();
    wr(CTRL_ADDR, 8'h40);
    go();
    repeat (40) @(posedge pclk);
    tick_en <= 1'b0;
    rdc(CTRL_ADDR, 8'hC0);
    chk("irq_masked", 32'h0, {31'h0, dog_irq});
    global_irq_enable <= 1'b1;
    wait_evt(1'b1, 10, 1'b0);
    chk("irq_taken", 32'h1, {31'h0, hit});
    wr(CTRL_ADDR, 8'hC0);
    rdc(CTRL_ADDR, 8'h40);
    chk("irq_cleared", 32'h0, {31'h0, dog_irq});
    go();
    wait_evt(1'b1, 100, 1'b1);
    chk("irq_again", 32'h1, {31'h0, hit});
    pulse(2);
    rdc(CTRL_ADDR, 8'h40);
  endtask

  task automatic t_comb();
    wr(CTRL_ADDR, 8'h48);
    go();
    wait_evt(1'b1, 100, 1'b1);
    chk("comb_irq", 32'h1, {31'h0, hit});
    pulse(2);
    rdc(CTRL_ADDR, 8'h08);
    wr(CTRL_ADDR, 8'h48);
    go();
    wait_evt(1'b1, 100, 1'b0);
    wait_evt(1'b0, 100, 1'b1);
    chk("second_timeout", 32'h1, {31'h0, hit});
    rdc(CAUSE_ADDR, 8'h08);
    rdc(CTRL_ADDR, 8'h08);
    setc(8'h00);
    rdc(CTRL_ADDR, 8'h08);
    wr(CAUSE_ADDR, 8'h00);
    setc(8'h00);
    rdc(CTRL_ADDR, 8'h00);
  endtask

  task automatic t_fuse();
    dog_force_on_fuse <= 1'b0;
    rdc(CTRL_ADDR, 8'h08);
    wr(CTRL_ADDR, 8'h40);
    rdc(CTRL_ADDR, 8'h08);
    go();
    wait_evt(1'b0, 100, 1'b1);
    chk("fuse_reset", 32'h1, {31'h0, hit});
    chk("fuse_no_irq", 32'h0, {31'h0, dog_irq});
    dog_force_on_fuse <= 1'b1;
    wr(CAUSE_ADDR, 8'h00);
    setc(8'h00);
    rdc(CTRL_ADDR, 8'h00);
  endtask

  // A second power-on reset in mid-run must wipe the pin flag but restore the power-up flag.
  task automatic t_por();
    pulse(0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CAUSE_ADDR, 8'h01);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #300000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cause();
    t_lock();
    t_restart();
    t_irq();
    t_comb();
    t_fuse();
    t_period();
    t_por();
    conclude();
  end
endmodule
